// ==== rtl/dsmtc_pkg.sv ====
/*
 * Constants and types for the drive speed monitor and terminal control block.
 * Assumes a 250 MHz pclk; times are held in units of 0.1 s and in Hz.
 */
package dsmtc_pkg;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned TENTH_S_NS = 100000000;
    localparam int unsigned CLK_PERIOD_NS = 1000 / CLK_MHZ;
    localparam int unsigned TENTH_S_CYCLES = TENTH_S_NS / CLK_PERIOD_NS;
    localparam int unsigned FLASH_TENTHS = 5;

    // ************************************************************
    // Fixed values, times in tenths of a second
    // ************************************************************
    localparam logic [7:0] FIXED_TIME_TENTHS = 8'h0a;
    localparam logic [7:0] FIXED_SETPOINT_HZ = 8'h05;
    localparam logic [7:0] BUS_MIN_FREQ_HZ = 8'h02;

    // ************************************************************
    // APB register map
    // ************************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
    localparam logic [7:0] ADDR_SETTINGS = 8'h10;
    localparam logic [7:0] ADDR_SPEED = 8'h14;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

    // Speed phase of the monitor
    typedef enum logic [1:0] {
        DSMTC_IDLE = 2'b00,
        DSMTC_ACCEL = 2'b01,
        DSMTC_STEADY = 2'b10,
        DSMTC_DECEL = 2'b11
    } dsmtc_phase_type;

    // Status LED state
    typedef enum logic [1:0] {
        DSMTC_LED_OFF = 2'b00,
        DSMTC_LED_FLASH_YELLOW = 2'b01,
        DSMTC_LED_YELLOW = 2'b10,
        DSMTC_LED_GREEN = 2'b11
    } dsmtc_led_type;
endpackage

// ==== rtl/dsmtc_ctrl.sv ====
/*
 * Drive speed monitor and terminal control: mode decode, selector tables,
 * phase-based speed monitoring with fault, LED and relay decode, APB slave.
 * Assumes terminal, switch and speed inputs are synchronous to pclk.
 */
// The APB interface to the registers and the address map were chosen for this implementation.
// Behaviour
// - With extended monitoring active, speed monitoring stays on whatever the config switch says.
// - Address zero selects terminal operation, any nonzero address selects bus operation.
// - Terminal mode, switch off: time 2 from ramp selector, times 1/3 and ramp 1 s, setpoint from selector 2.
// - Terminal mode, switch on: time 2 from selector 2, times 1/3 1 s, setpoint 5 Hz, ramp from selector.
// - Bus mode, switch off: time 2 from ramp selector, times 1/3 from selector 2, ramp 1 s, minimum 2 Hz.
// - Bus mode, switch on: time 2 from selector 2, times 1/3 1 s, ramp from selector, minimum 2 Hz.
// - Monitoring time positions 0..9 give 0.1..1.0 s and position 10 gives 1.5 s.
// - Monitoring time 1 applies while speed rises toward a higher setpoint.
// - Monitoring time 2 applies from the moment the setpoint is reached; no deviation is timed in steady state, so time 2 never faults.
// - Monitoring time 3 applies while speed falls toward a lower setpoint.
// - Without brake functions or extended monitoring the relay is a ready contact, otherwise it is the brake relay.
// - In terminal mode a running command uses the analog setpoint while select is low.
// - Select high uses setpoint 2, positions giving 5,7,10,15,20,25,35,50,60,70,100 Hz.
// - Ramp positions give 0.1,0.2,0.3,0.5,0.7,1,2,3,5,7,10 s per 50 Hz step.
// - LED off without supply, flashing yellow without mains, yellow stop, green run.
`timescale 1ns/10ps
`default_nettype none
module dsmtc_ctrl
    import dsmtc_pkg::*;
#(
    parameter int unsigned TENTH_CYCLES = TENTH_S_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic [3:0] address_switch,
    input wire logic speed_config_switch,
    input wire logic [3:0] ramp_selector,
    input wire logic [3:0] second_setpoint_selector,
    input wire logic [7:0] first_setpoint_pot,
    input wire logic setpoint_select_input,
    input wire logic run_clockwise_input,
    input wire logic run_counterclockwise_input,
    input wire logic control_supply_ok,
    input wire logic mains_ok,
    input wire logic [7:0] actual_speed_hz,
    output logic bus_mode,
    output logic [7:0] setpoint_hz,
    output logic [7:0] min_freq_hz,
    output logic [7:0] ramp_tenths,
    output logic run_enable,
    output logic run_ccw,
    output logic [1:0] led_state,
    output logic output_relay,
    output logic speed_fault
);
    // ************************************************************
    // Selector tables
    // ************************************************************
    function automatic logic [7:0] monitor_tenths(input logic [3:0] pos);
        // Positions above 10 saturate at the top detent
        if (pos >= 4'ha) begin
            return 8'h0f;
        end
        return {4'h0, pos} + 8'h01;
    endfunction

    function automatic logic [7:0] setpoint2_hz(input logic [3:0] pos);
        case (pos)
            4'h0: return 8'h05;
            4'h1: return 8'h07;
            4'h2: return 8'h0a;
            4'h3: return 8'h0f;
            4'h4: return 8'h14;
            4'h5: return 8'h19;
            4'h6: return 8'h23;
            4'h7: return 8'h32;
            4'h8: return 8'h3c;
            4'h9: return 8'h46;
            default: return 8'h64;
        endcase
    endfunction

    function automatic logic [7:0] ramp_table(input logic [3:0] pos);
        case (pos)
            4'h0: return 8'h01;
            4'h1: return 8'h02;
            4'h2: return 8'h03;
            4'h3: return 8'h05;
            4'h4: return 8'h07;
            4'h5: return 8'h0a;
            4'h6: return 8'h14;
            4'h7: return 8'h1e;
            4'h8: return 8'h32;
            4'h9: return 8'h46;
            default: return 8'h64;
        endcase
    endfunction

    // ************************************************************
    // Register state
    // ************************************************************
    logic [2:0] ctrl; // 0: extended monitoring, 1: brake function, 2: fault reset pulse
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [7:0] time1;
    logic [7:0] time2;
    logic [7:0] time3;
    logic [7:0] target_hz;
    logic [7:0] next_setpoint;
    logic monitor_on;
    dsmtc_phase_type phase;
    dsmtc_phase_type next_phase;
    logic [7:0] phase_limit;
    logic [7:0] tenth_count;
    logic [31:0] cycle_count;
    logic [31:0] flash_count;
    logic flash;
    logic wr_en;
    logic run_cmd;
    logic deviating;

    assign wr_en = psel && penable && pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // ************************************************************
    // Mode and setting decode
    // ************************************************************
    // address zero test
    assign bus_mode = (address_switch != 4'h0);
    assign monitor_on = ctrl[0];
    assign run_cmd = run_clockwise_input ^ run_counterclockwise_input;

    // Setting selection per operating mode
    always_comb begin
        time1 = FIXED_TIME_TENTHS;
        time3 = FIXED_TIME_TENTHS;
        min_freq_hz = 8'h00;
        time2 = speed_config_switch ? monitor_tenths(second_setpoint_selector) : monitor_tenths(ramp_selector);
        ramp_tenths = speed_config_switch ? ramp_table(ramp_selector) : FIXED_TIME_TENTHS;
        target_hz = setpoint2_hz(second_setpoint_selector);
        if (!bus_mode) begin
            if (speed_config_switch) begin
                target_hz = FIXED_SETPOINT_HZ;
            end
        end else begin
            min_freq_hz = BUS_MIN_FREQ_HZ;
            if (!speed_config_switch) begin
                time1 = monitor_tenths(second_setpoint_selector);
                time3 = monitor_tenths(second_setpoint_selector);
            end
        end
        next_setpoint = setpoint_select_input ? target_hz : first_setpoint_pot;
        if (!run_cmd || !mains_ok || !control_supply_ok || speed_fault) begin
            next_setpoint = 8'h00;
        end
    end

    // Registered setpoint and direction outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setpoint_hz <= 8'h00;
            run_enable <= 1'b0;
            run_ccw <= 1'b0;
        end else if (clk_en) begin
            setpoint_hz <= next_setpoint;
            run_enable <= run_cmd && mains_ok && control_supply_ok && !speed_fault;
            run_ccw <= run_counterclockwise_input && !run_clockwise_input;
        end
    end

    // ************************************************************
    // Phase tracking and speed monitor
    // ************************************************************
    // Phase follows actual speed against the setpoint
    always_comb begin
        if (actual_speed_hz < setpoint_hz) begin
            next_phase = DSMTC_ACCEL;
        end else if (actual_speed_hz > setpoint_hz) begin
            next_phase = DSMTC_DECEL;
        end else begin
            next_phase = DSMTC_STEADY;
        end
        case (phase)
            DSMTC_ACCEL: phase_limit = time1;
            DSMTC_STEADY: phase_limit = time2;
            DSMTC_DECEL: phase_limit = time3;
            default: phase_limit = 8'hff;
        endcase
    end

    // Deviation: outside steady state the ramp must move within the phase time
    assign deviating = monitor_on && run_enable && (phase != DSMTC_STEADY) && (phase != DSMTC_IDLE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= DSMTC_IDLE;
        end else if (clk_en) begin
            phase <= run_enable ? next_phase : DSMTC_IDLE;
        end
    end

    // Deviation timer in tenths; restarts whenever the phase changes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cycle_count <= 32'h0;
            tenth_count <= 8'h00;
        end else if (clk_en) begin
            if (!deviating || (next_phase != phase)) begin
                cycle_count <= 32'h0;
                tenth_count <= 8'h00;
            end else if (cycle_count >= TENTH_CYCLES - 1) begin
                cycle_count <= 32'h0;
                if (tenth_count != 8'hff) begin
                    tenth_count <= tenth_count + 8'h01;
                end
            end else begin
                cycle_count <= cycle_count + 32'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed_fault <= 1'b0;
        end else if (clk_en) begin
            if (deviating && (tenth_count >= phase_limit)) begin
                speed_fault <= 1'b1;
            end else if (ctrl[2] && !run_cmd) begin
                speed_fault <= 1'b0;
            end
        end
    end

    // ************************************************************
    // LED and relay
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_count <= 32'h0;
            flash <= 1'b0;
        end else if (clk_en) begin
            if (flash_count >= TENTH_CYCLES * FLASH_TENTHS - 1) begin
                flash_count <= 32'h0;
                flash <= !flash;
            end else begin
                flash_count <= flash_count + 32'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            led_state <= DSMTC_LED_OFF;
        end else if (clk_en) begin
            if (!control_supply_ok) begin
                led_state <= DSMTC_LED_OFF;
            end else if (!mains_ok) begin
                led_state <= flash ? DSMTC_LED_FLASH_YELLOW : DSMTC_LED_OFF;
            end else if (run_cmd) begin
                led_state <= DSMTC_LED_GREEN;
            end else begin
                led_state <= DSMTC_LED_YELLOW;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_relay <= 1'b0;
        end else if (clk_en) begin
            if (ctrl[1] || ctrl[0]) begin
                output_relay <= run_enable;
            end else begin
                output_relay <= control_supply_ok && mains_ok && !speed_fault;
            end
        end
    end

    // ************************************************************
    // APB registers and interrupt
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
            irq_mask <= IRQ_MASK_RESET;
        end else if (clk_en) begin
            ctrl[2] <= 1'b0;
            if (wr_en && (paddr == ADDR_CTRL)) begin
                ctrl <= pwdata[2:0];
            end else if (wr_en && (paddr == ADDR_IRQ_MASK)) begin
                irq_mask <= pwdata[1:0];
            end
        end
    end

    // Sticky events; set wins over a write-one clear in the same cycle
    logic [1:0] irq_clr;
    logic [1:0] irq_set;
    assign irq_clr = (wr_en && (paddr == ADDR_IRQ_STATUS)) ? pwdata[1:0] : 2'h0;
    assign irq_set = {(next_phase == DSMTC_STEADY) && (phase == DSMTC_ACCEL || phase == DSMTC_DECEL),
                      deviating && (tenth_count >= phase_limit) && !speed_fault};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= 2'h0;
        end else if (clk_en) begin
            irq_status <= (irq_status & ~irq_clr) | irq_set;
        end
    end

    assign irq = |(irq_status & irq_mask);

    // Read data registered; unmapped reads return zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (clk_en) begin
            if (paddr == ADDR_CTRL) begin
                prdata <= {29'h0, ctrl};
            end else if (paddr == ADDR_STATUS) begin
                prdata <= {22'h0, led_state, phase, output_relay, run_ccw, run_enable, speed_fault, monitor_on, bus_mode};
            end else if (paddr == ADDR_IRQ_STATUS) begin
                prdata <= {30'h0, irq_status};
            end else if (paddr == ADDR_IRQ_MASK) begin
                prdata <= {30'h0, irq_mask};
            end else if (paddr == ADDR_SETTINGS) begin
                prdata <= {time1, time2, time3, ramp_tenths};
            end else if (paddr == ADDR_SPEED) begin
                prdata <= {8'h00, min_freq_hz, setpoint_hz, tenth_count};
            end else begin
                prdata <= 32'h0;
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_bus_mode;
        @(posedge pclk) disable iff (!presetn) (address_switch == 4'h0) |-> !bus_mode;
    endproperty
    a_bus_mode: assert property (p_bus_mode) else $error("terminal mode not selected at address zero");

    property p_fixed_terminal;
        @(posedge pclk) disable iff (!presetn)
            (!bus_mode && speed_config_switch) |-> (target_hz == 8'h05 && time1 == 8'h0a && time3 == 8'h0a);
    endproperty
    a_fixed_terminal: assert property (p_fixed_terminal) else $error("terminal fixed values wrong");

    property p_ramp_fixed;
        @(posedge pclk) disable iff (!presetn) !speed_config_switch |-> (ramp_tenths == 8'h0a);
    endproperty
    a_ramp_fixed: assert property (p_ramp_fixed) else $error("ramp not fixed at 1 s");

    property p_bus_min;
        @(posedge pclk) disable iff (!presetn) bus_mode |-> (min_freq_hz == 8'h02);
    endproperty
    a_bus_min: assert property (p_bus_min) else $error("bus minimum frequency not 2 Hz");

    property p_time_top;
        @(posedge pclk) disable iff (!presetn)
            (!bus_mode && !speed_config_switch && ramp_selector == 4'ha) |-> (time2 == 8'h0f);
    endproperty
    a_time_top: assert property (p_time_top) else $error("position 10 not 1.5 s");

    sequence s_stable_run;
        clk_en && run_cmd && mains_ok && control_supply_ok && !speed_fault;
    endsequence
    property p_run_setpoint;
        @(posedge pclk) disable iff (!presetn)
            (s_stable_run ##0 (setpoint_select_input == 1'b0)) |=> (!clk_en || setpoint_hz == $past(first_setpoint_pot));
    endproperty
    a_run_setpoint: assert property (p_run_setpoint) else $error("analog setpoint not used");

    property p_led_off;
        @(posedge pclk) disable iff (!presetn) (clk_en && !control_supply_ok) |=> (led_state == DSMTC_LED_OFF);
    endproperty
    a_led_off: assert property (p_led_off) else $error("LED lit without supply");

    property p_fault_inhibit;
        @(posedge pclk) disable iff (!presetn) (clk_en && speed_fault) |=> !run_enable;
    endproperty
    a_fault_inhibit: assert property (p_fault_inhibit) else $error("output not inhibited on fault");
endmodule // dsmtc_ctrl
`default_nettype wire

// ==== verif/dsmtc_terminal_model.sv ====
/*
 * Outside controller on the binary terminals, plus a plant whose speed
 * follows the setpoint. Assumes the bench's pclk and presetn.
 */
`timescale 1ns/10ps
`default_nettype none
module dsmtc_terminal_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cmd_cw,
    input wire logic cmd_ccw,
    input wire logic cmd_sel,
    input wire logic cmd_sup,
    input wire logic cmd_mains,
    input wire logic stall,
    input wire logic run_enable,
    input wire logic [7:0] setpoint_hz,
    output logic run_clockwise_input,
    output logic run_counterclockwise_input,
    output logic setpoint_select_input,
    output logic control_supply_ok,
    output logic mains_ok,
    output logic [7:0] actual_speed_hz
);
    // ********************
    // Terminals and plant
    // ********************
    // Terminals move one edge after the command, like an output card
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_clockwise_input <= 1'b0;
            run_counterclockwise_input <= 1'b0;
            setpoint_select_input <= 1'b0;
            control_supply_ok <= 1'b0;
            mains_ok <= 1'b0;
        end else begin
            run_clockwise_input <= cmd_cw;
            run_counterclockwise_input <= cmd_ccw;
            setpoint_select_input <= cmd_sel;
            control_supply_ok <= cmd_sup;
            mains_ok <= cmd_mains;
        end
    end
    // Stall freezes speed so the monitor sees a lasting deviation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            actual_speed_hz <= 8'h00;
        end else if (!stall) begin
            actual_speed_hz <= run_enable ? setpoint_hz : 8'h00;
        end
    end
endmodule // dsmtc_terminal_model
`default_nettype wire

// ==== verif/drive_speed_monitor_terminal_ctrl_test.sv ====
/*
 * Self-checking bench: APB tasks plus terminal commands through the model.
 * Assumes dsmtc_pkg, dsmtc_ctrl and dsmtc_terminal_model compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
module drive_speed_monitor_terminal_ctrl_test;
    import dsmtc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] address_switch = 4'h0;
    logic speed_config_switch = 1'b0;
    logic [3:0] ramp_selector = 4'h0;
    logic [3:0] second_setpoint_selector = 4'h0;
    logic [7:0] first_setpoint_pot = 8'h32;
    logic cw = 1'b0, ccw = 1'b0, sel = 1'b0, sup = 1'b0, mains = 1'b0, stall = 1'b0, en = 1'b1;
    logic [31:0] prdata, rd_q, q;
    logic pready, pslverr, irq, bus_mode, run_enable, run_ccw, output_relay, speed_fault, go;
    logic run_clockwise_input, run_counterclockwise_input, setpoint_select_input, control_supply_ok, mains_ok;
    logic [7:0] actual_speed_hz, setpoint_hz, min_freq_hz, ramp_tenths, t13, t2, rmp;
    logic [1:0] led_state;
    int err_total = 0;
    int checks_done = 0;
    int n, lit, bad;
    // Monitoring time and ramp in tenths, second setpoint in Hz
    logic [7:0] mon_t [0:10] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0f};
    logic [7:0] ramp_t [0:10] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h07, 8'h0a, 8'h14, 8'h1e, 8'h32, 8'h46, 8'h64};
    logic [7:0] sp_t [0:10] = '{8'h05, 8'h07, 8'h0a, 8'h0f, 8'h14, 8'h19, 8'h23, 8'h32, 8'h3c, 8'h46, 8'h64};

    // Short tenth so monitoring times span tens of cycles
    dsmtc_ctrl #(.TENTH_CYCLES(4)) uut (
        .pclk, .presetn, .clk_en(en), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .irq, .address_switch, .speed_config_switch, .ramp_selector, .second_setpoint_selector,
        .first_setpoint_pot, .setpoint_select_input, .run_clockwise_input, .run_counterclockwise_input,
        .control_supply_ok, .mains_ok, .actual_speed_hz, .bus_mode, .setpoint_hz, .min_freq_hz, .ramp_tenths,
        .run_enable, .run_ccw, .led_state, .output_relay, .speed_fault
    );
    dsmtc_terminal_model partner (
        .pclk, .presetn, .cmd_cw(cw), .cmd_ccw(ccw), .cmd_sel(sel), .cmd_sup(sup), .cmd_mains(mains), .stall,
        .run_enable, .setpoint_hz, .run_clockwise_input, .run_counterclockwise_input, .setpoint_select_input,
        .control_supply_ok, .mains_ok, .actual_speed_hz
    );

    // ********************
    // Clock and bus tasks
    // ********************
    always #2 pclk = ~pclk;
    // Read data as it stood at the accepting edge, free of races
    always @(posedge pclk) rd_q <= prdata;

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            do begin
                @(posedge pclk);
            end while (pready !== 1'b1);
            chk({31'h0, pslverr}, 32'h0);
            psel <= 1'b0;
            penable <= 1'b0;
            @(negedge pclk);
            q = rd_q;
        end
    endtask

    task automatic idle(input int c);
        repeat (c) @(posedge pclk);
        @(negedge pclk);
    endtask

    task automatic term(input logic c, input logic cc, input logic s, input logic su, input logic m);
        @(posedge pclk);
        cw <= c;
        ccw <= cc;
        sel <= s;
        sup <= su;
        mains <= m;
        idle(3);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Watchdog, several times the expected run length
    initial begin
        #40000;
        err_total++;
        tally_and_finish();
    end

    // ********************
    // Tests
    // ********************
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and an unmapped read
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, ADDR_IRQ_MASK, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk(q, 32'h0);
        $display("test reset done");
        // Terminal table; flashing case handled below
        for (int i = 0; i < 16; i++) begin
            if (i[3:2] != 2'b10) begin
                term(i[0], i[1], 1'b0, i[3], i[2]);
                go = i[3] & i[2] & (i[0] ^ i[1]);
                chk({30'h0, led_state}, {30'h0, !i[3] ? DSMTC_LED_OFF : (i[0] == i[1]) ? DSMTC_LED_YELLOW
                    : DSMTC_LED_GREEN});
                chk({31'h0, run_enable}, {31'h0, go});
                if (go) chk({31'h0, run_ccw}, {31'h0, i[1]});
                chk({24'h0, setpoint_hz}, go ? 32'h32 : 32'h0);
            end
        end
        term(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        lit = 0;
        bad = 0;
        repeat (60) begin
            @(negedge pclk);
            if (led_state === DSMTC_LED_FLASH_YELLOW) lit++;
            else if (led_state !== DSMTC_LED_OFF) bad++;
        end
        chk({31'h0, lit > 0 && lit < 60 && bad == 0}, 32'h1);
        $display("test terminals done");
        // Every mode and selector position, extended monitoring on
        apb(1'b1, ADDR_CTRL, 32'h1);
        term(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
        for (int m = 0; m < 4; m++) begin
            for (int p = 0; p <= 10; p++) begin
                @(posedge pclk);
                address_switch <= m[1] ? 4'(1 << (p % 4)) : 4'h0;
                speed_config_switch <= m[0];
                ramp_selector <= 4'(p);
                second_setpoint_selector <= 4'(10 - p);
                idle(4);
                t13 = (m == 2) ? mon_t[10 - p] : FIXED_TIME_TENTHS;
                t2 = m[0] ? mon_t[10 - p] : mon_t[p];
                rmp = m[0] ? ramp_t[p] : FIXED_TIME_TENTHS;
                chk({24'h0, ramp_tenths}, {24'h0, rmp});
                chk({31'h0, bus_mode}, {31'h0, m[1]});
                chk({24'h0, min_freq_hz}, {24'h0, m[1] ? BUS_MIN_FREQ_HZ : 8'h00});
                if (!m[1]) chk({24'h0, setpoint_hz}, {24'h0, m[0] ? FIXED_SETPOINT_HZ : sp_t[10 - p]});
                apb(1'b0, ADDR_SETTINGS, 32'h0);
                chk(q, {t13, t2, t13, rmp});
                apb(1'b0, ADDR_STATUS, 32'h0);
                chk({31'h0, q[1]}, 32'h1);
            end
        end
        $display("test modes done");
        // Phases and a lasting deviation; times 1 and 3 are 40 cycles
        @(posedge pclk);
        address_switch <= 4'h0;
        speed_config_switch <= 1'b0;
        ramp_selector <= 4'h3;
        term(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
        apb(1'b1, ADDR_IRQ_STATUS, 32'h3);
        @(posedge pclk);
        stall <= 1'b1;
        term(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({30'h0, q[7:6]}, {30'h0, DSMTC_ACCEL});
        @(posedge pclk);
        stall <= 1'b0;
        idle(4);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({30'h0, q[7:6]}, {30'h0, DSMTC_STEADY});
        apb(1'b0, ADDR_SPEED, 32'h0);
        chk(q, 32'h3200);
        apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
        chk({31'h0, q[1]}, 32'h1);
        @(posedge pclk);
        stall <= 1'b1;
        first_setpoint_pot <= 8'h14;
        idle(3);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({30'h0, q[7:6]}, {30'h0, DSMTC_DECEL});
        n = 0;
        while (speed_fault !== 1'b1 && n < 100) begin
            @(negedge pclk);
            n++;
        end
        chk({31'h0, speed_fault === 1'b1 && n >= 25}, 32'h1);
        idle(2);
        chk({31'h0, run_enable}, 32'h0);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, ADDR_IRQ_MASK, 32'h1);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h0);
        @(posedge pclk);
        stall <= 1'b0;
        term(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
        apb(1'b1, ADDR_CTRL, 32'h5);
        idle(2);
        chk({31'h0, speed_fault}, 32'h0);
        $display("test monitoring done");
        // Relay role per extended monitoring and brake function bits, drive stopped
        for (int c = 0; c < 3; c++) begin
            apb(1'b1, ADDR_CTRL, 32'(c));
            idle(2);
            chk({31'h0, output_relay}, {31'h0, c == 0});
        end
        term(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
        chk({31'h0, output_relay}, 32'h1);
        // Enable low freezes the setpoint register
        @(posedge pclk);
        en <= 1'b0;
        first_setpoint_pot <= 8'h32;
        idle(4);
        chk({24'h0, setpoint_hz}, 32'h14);
        @(posedge pclk);
        en <= 1'b1;
        idle(2);
        chk({24'h0, setpoint_hz}, 32'h32);
        $display("test relay done");
        tally_and_finish();
    end
endmodule // drive_speed_monitor_terminal_ctrl_test
`default_nettype wire
